// ---- rtl/sbg_pkg.sv ----
// shared constants and types for the serial block former and access guard
package sbg_pkg;
	localparam int CLK_HZ = 50000000;
	// ============================================================
	// timing
	localparam int TOTAL_READ_MS = 50;
	localparam int CHAR_GAP_MS = 5;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int TOTAL_READ_CYC = TOTAL_READ_MS * MS_CYCLES;
	localparam int CHAR_GAP_CYC = CHAR_GAP_MS * MS_CYCLES;
	localparam int MINUTE_MS = 60000;
	// ============================================================
	// APB register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FRAME = 8'h04;
	localparam logic [7:0] REG_GUARD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_ARG_LO = 8'h14;
	localparam logic [7:0] REG_ARG_HI = 8'h18;
	localparam logic [7:0] REG_RESP_LO = 8'h1C;
	localparam logic [7:0] REG_RESP_HI = 8'h20;
	localparam logic [7:0] REG_CALL = 8'h24;
	localparam logic [7:0] REG_BLOCK = 8'h28;
	// ============================================================
	// field positions
	localparam int FRAME_EN_BIT = 0;
	localparam int FRAME_FMT_LSB = 1;
	localparam int FRAME_FIX_LSB = 8;
	localparam int FRAME_UDL_LSB = 16;
	localparam int GUARD_EN_BIT = 0;
	localparam int GUARD_LOCK_LSB = 8;
	// ============================================================
	// reset values
	localparam logic FRAME_EN_RST = 1'b0;
	localparam logic [1:0] FRAME_FMT_RST = 2'h1;
	localparam logic [7:0] FRAME_FIX_RST = 8'h02;
	localparam logic [7:0] FRAME_UDL_RST = 8'h02;
	localparam logic GUARD_EN_RST = 1'b0;
	localparam logic [7:0] LOCK_MIN_RST = 8'h03;
	localparam logic [1:0] MAX_TRIES = 2'h3;
	// ============================================================
	// frame formats and start characters
	typedef enum logic [1:0] {
		SBG_FT11 = 2'h0,
		SBG_FT12 = 2'h1,
		SBG_FT2 = 2'h2,
		SBG_FT3 = 2'h3
	} sbg_fmt_t;
	localparam logic [7:0] FT12_VAR_START = 8'h68;
	localparam logic [7:0] FT12_FIX_START = 8'h10;
	localparam logic [7:0] FT12_END = 8'h16;
	localparam logic [7:0] FT3_START = 8'h05;
	// ============================================================
	// guard commands written to the command register
	typedef enum logic [3:0] {
		SBG_CMD_NONE = 4'h0,
		SBG_CMD_ENTER = 4'h1,
		SBG_CMD_SET_MASTER = 4'h2,
		SBG_CMD_SET_USER = 4'h3,
		SBG_CMD_QUERY_SECRET = 4'h4,
		SBG_CMD_LIST_SECRETS = 4'h5,
		SBG_CMD_SET_CALLER = 4'h6,
		SBG_CMD_QUERY_CALLER = 4'h7,
		SBG_CMD_LIST_CALLERS = 4'h8,
		SBG_CMD_SAVE = 4'h9,
		SBG_CMD_LEAVE = 4'hA,
		SBG_CMD_FACTORY = 4'hB,
		SBG_CMD_CALL = 4'hC,
		SBG_CMD_SECRET = 4'hD
	} sbg_cmd_t;
	// result codes
	localparam logic [3:0] RES_OK = 4'h0;
	localparam logic [3:0] RES_CONNECT = 4'h1;
	localparam logic [3:0] RES_ERROR = 4'h4;
	localparam logic [3:0] RES_DENIED = 4'h8;
	localparam logic [3:0] RES_PROMPT = 4'hA;
	localparam logic [3:0] RES_WRONG = 4'hC;
endpackage

// ---- rtl/sbg_blk_if.sv ----
// block former link between the top and the former module
`timescale 1ns/10ps
interface sbg_blk_if;
	logic [7:0] rx_data;
	logic rx_valid;
	logic frame_en;
	logic [1:0] frame_fmt;
	logic [7:0] fix_len;
	logic [7:0] udl_len;
	logic flush;
	logic [1:0] flush_cause;
	logic [7:0] flush_count;
	modport former (input rx_data, rx_valid, frame_en, frame_fmt, fix_len, udl_len,
		output flush, flush_cause, flush_count);
	modport ctrl (output rx_data, rx_valid, frame_en, frame_fmt, fix_len, udl_len,
		input flush, flush_cause, flush_count);
endinterface

// ---- rtl/sbg_former.sv ----
// serial block former: timers and frame recogniser
`timescale 1ns/10ps
module sbg_former #(
	parameter int TOTAL_CYC = sbg_pkg::TOTAL_READ_CYC,
	parameter int GAP_CYC = sbg_pkg::CHAR_GAP_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// link to control
	sbg_blk_if.former bi
);
	import sbg_pkg::*;
	logic [21:0] tot_q, tot_d;
	logic [21:0] gap_q, gap_d;
	logic [7:0] cnt_q, cnt_d;
	logic [7:0] need_q, need_d;
	logic act_q, act_d;
	logic flush_q, flush_d;
	logic [1:0] cause_q, cause_d;
	logic [7:0] fcnt_q, fcnt_d;
	logic [7:0] n;
	logic frame_done;
	assign bi.flush = flush_q;
	assign bi.flush_cause = cause_q;
	assign bi.flush_count = fcnt_q;
	// ============================================================
	// frame recognition
	always_comb begin
		n = cnt_q + 8'h01;
		frame_done = 1'b0;
		need_d = need_q;
		if (bi.rx_valid && bi.frame_en) begin
			if (cnt_q == 8'h00) begin
				case (sbg_fmt_t'(bi.frame_fmt))
					SBG_FT11: need_d = bi.fix_len;
					SBG_FT12: need_d = (bi.rx_data == FT12_VAR_START) ? 8'hFF : bi.fix_len;
					default: need_d = 8'(bi.udl_len + 8'h03);
				endcase
			end else if (cnt_q == 8'h01 && bi.frame_fmt == SBG_FT12 && need_q == 8'hFF) begin
				need_d = 8'(bi.rx_data + 8'h06);
			end
			frame_done = (n == need_d) && (need_d != 8'hFF);
		end
	end
	// ============================================================
	// timers and flush
	always_comb begin
		tot_d = tot_q;
		gap_d = gap_q;
		cnt_d = cnt_q;
		act_d = act_q;
		flush_d = 1'b0;
		cause_d = cause_q;
		fcnt_d = fcnt_q;
		if (bi.rx_valid) begin
			cnt_d = n;
			gap_d = 22'h0;
			if (!act_q) begin
				act_d = 1'b1;
				tot_d = 22'h0;
			end else begin
				tot_d = tot_q + 22'h1;
			end
			if (frame_done) begin
				flush_d = 1'b1;
				cause_d = 2'h2;
				fcnt_d = n;
			end else if (act_q && tot_q >= 22'(TOTAL_CYC - 1)) begin
				flush_d = 1'b1;
				cause_d = 2'h0;
				fcnt_d = n;
			end
		end else if (act_q) begin
			tot_d = tot_q + 22'h1;
			gap_d = gap_q + 22'h1;
			if (tot_q >= 22'(TOTAL_CYC - 1)) begin
				flush_d = 1'b1;
				cause_d = 2'h0;
				fcnt_d = cnt_q;
			end else if (gap_q >= 22'(GAP_CYC)) begin
				flush_d = 1'b1;
				cause_d = 2'h1;
				fcnt_d = cnt_q;
			end
		end
		if (flush_d) begin
			act_d = 1'b0;
			cnt_d = 8'h00;
			tot_d = 22'h0;
			gap_d = 22'h0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tot_q <= 22'h0;
			gap_q <= 22'h0;
			cnt_q <= 8'h00;
			need_q <= 8'h00;
			act_q <= 1'b0;
			flush_q <= 1'b0;
			cause_q <= 2'h0;
			fcnt_q <= 8'h00;
		end else begin
			tot_q <= tot_d;
			gap_q <= gap_d;
			cnt_q <= cnt_d;
			need_q <= need_d;
			act_q <= act_d;
			flush_q <= flush_d;
			cause_q <= cause_d;
			fcnt_q <= fcnt_d;
		end
	end
endmodule

// ---- rtl/sbg_lock_timer.sv ----
// lockout minute timer
`timescale 1ns/10ps
module sbg_lock_timer #(
	parameter longint MINUTE_CYC = longint'(sbg_pkg::MINUTE_MS) * sbg_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic start,
	input wire logic [7:0] minutes,
	output logic busy
);
	logic [31:0] cyc_q, cyc_d;
	logic [7:0] min_q, min_d;
	logic busy_q, busy_d;
	assign busy = busy_q;
	always_comb begin
		cyc_d = cyc_q;
		min_d = min_q;
		busy_d = busy_q;
		if (start) begin
			busy_d = (minutes != 8'h00);
			min_d = minutes;
			cyc_d = 32'h0;
		end else if (busy_q) begin
			if (cyc_q >= 32'(MINUTE_CYC - 1)) begin
				cyc_d = 32'h0;
				min_d = min_q - 8'h01;
				if (min_q == 8'h01) begin
					busy_d = 1'b0;
				end
			end else begin
				cyc_d = cyc_q + 32'h1;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cyc_q <= 32'h0;
			min_q <= 8'h00;
			busy_q <= 1'b0;
		end else begin
			cyc_q <= cyc_d;
			min_q <= min_d;
			busy_q <= busy_d;
		end
	end
endmodule

// ---- rtl/sbg_top.sv ----
// serial block former and access guard with APB registers
// How it works
// - first byte starts total-read timer; expiry forwards gathered bytes
// - gap beyond character distance forwards gathered bytes
// - recognised complete frame forwards at once, no timer wait
// - format codes: 0 FT1.1, 1 FT1.2, 2 FT2, 3 FT3
// - FT2/FT3 header length uses the user-data length setting
// - factory reset restores only the frame settings; guard, secrets and callers keep their values
// - enter config needs master secret once one is set
// - set master with value replaces, empty value deletes
// - nine user secrets, 8 chars max, case ignored
// - query returns one secret; list returns one per command and steps the index, wrapping after 9
// - guard enable 1 requires secret, 0 removes requirement
// - three wrong secrets block requests until lockout elapses
// - frame and guard register writes take effect only after save
// - leave command exits configuration mode
// - guarded call gets secret prompt, waits for secret
// - only user secret connects; master never connects
// - wrong secret reports message; three tries total
// - third wrong secret reports denied, starts lockout
// - ten caller address slots, set or cleared by empty value
// - empty allow list accepts all; else only listed
// - query returns one slot; list returns one slot per command and steps the index, wrapping after 9
// - wrong-try counter is volatile, zero after reset
// - lockout time zero disables lockout
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
module sbg_top #(
	parameter int TOTAL_CYC = sbg_pkg::TOTAL_READ_CYC,
	parameter int GAP_CYC = sbg_pkg::CHAR_GAP_CYC,
	parameter longint MINUTE_CYC = longint'(sbg_pkg::MINUTE_MS) * sbg_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial receive bytes
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	// forwarded block event
	output logic blk_flush,
	output logic [1:0] blk_cause,
	output logic [7:0] blk_count,
	// guard state
	output logic config_mode,
	output logic link_up
);
	import sbg_pkg::*;
	// ============================================================
	// state
	typedef enum logic [3:0] {
		SBG_IDLE = 4'b0001,
		SBG_PROMPT = 4'b0010,
		SBG_LINKED = 4'b0100,
		SBG_LOCKED = 4'b1000
	} sbg_call_t;
	sbg_call_t call_q, call_d;
	logic [63:0] sec_q [0:9], sec_d [0:9];
	logic [31:0] ip_q [0:9], ip_d [0:9];
	logic [31:0] frame_q, frame_d, guard_q, guard_d;
	logic [31:0] frame_act_q, frame_act_d, guard_act_q, guard_act_d;
	logic [3:0] cmd_q, cmd_d;
	logic [3:0] idx_q, idx_d;
	logic [63:0] arg_q, arg_d;
	logic [63:0] resp_q, resp_d;
	logic [3:0] res_q, res_d;
	logic [7:0] tries_q, tries_d;
	logic [1:0] att_q, att_d;
	logic cfg_q, cfg_d;
	logic go_q, go_d;
	logic [31:0] caller_q, caller_d;
	logic [31:0] rdata;
	logic lock_start, lock_busy;
	logic wr_en;
	sbg_blk_if bi ();
	// ============================================================
	// helpers
	function automatic logic [63:0] fold(input logic [63:0] s);
		logic [63:0] r;
		r = s;
		for (int i = 0; i < 8; i++) begin
			if (s[i*8 +: 8] >= 8'h61 && s[i*8 +: 8] <= 8'h7A) begin
				r[i*8 +: 8] = s[i*8 +: 8] - 8'h20;
			end
		end
		return r;
	endfunction
	function automatic logic same(input logic [63:0] a, input logic [63:0] b);
		return fold(a) == fold(b);
	endfunction
	// ============================================================
	// block former
	assign bi.rx_data = rx_data;
	assign bi.rx_valid = rx_valid;
	assign bi.frame_en = frame_act_q[FRAME_EN_BIT];
	assign bi.frame_fmt = frame_act_q[FRAME_FMT_LSB +: 2];
	assign bi.fix_len = frame_act_q[FRAME_FIX_LSB +: 8];
	assign bi.udl_len = frame_act_q[FRAME_UDL_LSB +: 8];
	assign blk_flush = bi.flush;
	assign blk_cause = bi.flush_cause;
	assign blk_count = bi.flush_count;
	sbg_former #(.TOTAL_CYC(TOTAL_CYC), .GAP_CYC(GAP_CYC)) u_former (
		.core_clk(core_clk),
		.rst(rst),
		.bi(bi)
	);
	sbg_lock_timer #(.MINUTE_CYC(MINUTE_CYC)) u_lock (
		.core_clk(core_clk),
		.rst(rst),
		.start(lock_start),
		.minutes(guard_act_q[GUARD_LOCK_LSB +: 8]),
		.busy(lock_busy)
	);
	// ============================================================
	// apb access
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign config_mode = cfg_q;
	assign link_up = (call_q == SBG_LINKED);
	always_comb begin
		pslverr = 1'b0;
		rdata = 32'h0;
		if (paddr == REG_CTRL) begin
			rdata = {24'h0, idx_q, cmd_q};
		end else if (paddr == REG_FRAME) begin
			rdata = frame_q;
		end else if (paddr == REG_GUARD) begin
			rdata = guard_q;
		end else if (paddr == REG_STATUS) begin
			rdata = {16'h0, tries_q, call_q, res_q};
		end else if (paddr == REG_CMD) begin
			rdata = {27'h0, go_q, cmd_q};
		end else if (paddr == REG_ARG_LO) begin
			rdata = arg_q[31:0];
		end else if (paddr == REG_ARG_HI) begin
			rdata = arg_q[63:32];
		end else if (paddr == REG_RESP_LO) begin
			rdata = resp_q[31:0];
		end else if (paddr == REG_RESP_HI) begin
			rdata = resp_q[63:32];
		end else if (paddr == REG_CALL) begin
			rdata = caller_q;
		end else if (paddr == REG_BLOCK) begin
			rdata = {22'h0, blk_cause, blk_count};
		end else begin
			pslverr = psel && penable;
		end
		prdata = (psel && penable && !pwrite) ? rdata : 32'h0;
	end
	// ============================================================
	// command interpreter
	always_comb begin
		logic any_ip;
		logic ip_ok;
		logic user_ok;
		any_ip = 1'b0;
		ip_ok = 1'b0;
		user_ok = 1'b0;
		sec_d = sec_q;
		ip_d = ip_q;
		frame_d = frame_q;
		guard_d = guard_q;
		frame_act_d = frame_act_q;
		guard_act_d = guard_act_q;
		cmd_d = cmd_q;
		idx_d = idx_q;
		arg_d = arg_q;
		resp_d = resp_q;
		res_d = res_q;
		tries_d = tries_q;
		att_d = att_q;
		cfg_d = cfg_q;
		call_d = call_q;
		go_d = 1'b0;
		caller_d = caller_q;
		lock_start = 1'b0;
		if (wr_en) begin
			if (paddr == REG_CTRL) begin
				idx_d = pwdata[7:4];
			end else if (paddr == REG_FRAME && cfg_q) begin
				frame_d = pwdata;
			end else if (paddr == REG_GUARD && cfg_q) begin
				guard_d = pwdata;
			end else if (paddr == REG_CMD) begin
				cmd_d = pwdata[3:0];
				go_d = 1'b1;
			end else if (paddr == REG_ARG_LO) begin
				arg_d[31:0] = pwdata;
			end else if (paddr == REG_ARG_HI) begin
				arg_d[63:32] = pwdata;
			end else if (paddr == REG_CALL) begin
				caller_d = pwdata;
			end
		end
		for (int i = 0; i < 10; i++) begin
			any_ip = any_ip | (ip_q[i] != 32'h0);
			ip_ok = ip_ok | ((ip_q[i] != 32'h0) && (ip_q[i] == caller_q));
			if (i > 0) begin
				user_ok = user_ok | ((sec_q[i] != 64'h0) && same(sec_q[i], arg_q));
			end
		end
		if (go_q) begin
			res_d = RES_OK;
			case (sbg_cmd_t'(cmd_q))
				SBG_CMD_ENTER: begin
					if (sec_q[0] == 64'h0 || same(sec_q[0], arg_q)) begin
						cfg_d = 1'b1;
					end else begin
						res_d = RES_ERROR;
					end
				end
				SBG_CMD_SET_MASTER: begin
					if (cfg_q) sec_d[0] = arg_q;
					else res_d = RES_ERROR;
				end
				SBG_CMD_SET_USER: begin
					if (cfg_q && idx_q >= 4'h1 && idx_q <= 4'h9) sec_d[idx_q] = arg_q;
					else res_d = RES_ERROR;
				end
				SBG_CMD_QUERY_SECRET: begin
					if (cfg_q && idx_q <= 4'h9) resp_d = sec_q[idx_q];
					else res_d = RES_ERROR;
				end
				SBG_CMD_LIST_SECRETS: begin
					if (cfg_q) begin
						resp_d = sec_q[idx_q <= 4'h9 ? idx_q : 4'h0];
						idx_d = (idx_q >= 4'h9) ? 4'h0 : idx_q + 4'h1;
					end else res_d = RES_ERROR;
				end
				SBG_CMD_SET_CALLER: begin
					if (cfg_q && idx_q <= 4'h9) ip_d[idx_q] = arg_q[31:0];
					else res_d = RES_ERROR;
				end
				SBG_CMD_QUERY_CALLER: begin
					if (cfg_q && idx_q <= 4'h9) resp_d = {32'h0, ip_q[idx_q]};
					else res_d = RES_ERROR;
				end
				SBG_CMD_LIST_CALLERS: begin
					if (cfg_q) begin
						resp_d = {32'h0, ip_q[idx_q <= 4'h9 ? idx_q : 4'h0]};
						idx_d = (idx_q >= 4'h9) ? 4'h0 : idx_q + 4'h1;
					end else res_d = RES_ERROR;
				end
				SBG_CMD_SAVE: begin
					frame_act_d = frame_q;
					guard_act_d = guard_q;
				end
				SBG_CMD_LEAVE: cfg_d = 1'b0;
				SBG_CMD_FACTORY: begin
					frame_d = 32'h0;
					frame_d[FRAME_EN_BIT] = FRAME_EN_RST;
					frame_d[FRAME_FMT_LSB +: 2] = FRAME_FMT_RST;
					frame_d[FRAME_FIX_LSB +: 8] = FRAME_FIX_RST;
					frame_d[FRAME_UDL_LSB +: 8] = FRAME_UDL_RST;
					frame_act_d = frame_d;
				end
				SBG_CMD_CALL: begin
					if (any_ip && !ip_ok) begin
						res_d = RES_DENIED;
					end else if (call_q == SBG_LOCKED) begin
						res_d = RES_DENIED;
					end else if (guard_act_q[GUARD_EN_BIT]) begin
						call_d = SBG_PROMPT;
						att_d = 2'h0;
						res_d = RES_PROMPT;
					end else begin
						call_d = SBG_LINKED;
						res_d = RES_CONNECT;
					end
				end
				SBG_CMD_SECRET: begin
					if (call_q != SBG_PROMPT) begin
						res_d = RES_ERROR;
					end else if (user_ok) begin
						call_d = SBG_LINKED;
						res_d = RES_CONNECT;
					end else begin
						tries_d = tries_q + 8'h01;
						att_d = att_q + 2'h1;
						res_d = RES_WRONG;
						if (att_q + 2'h1 >= MAX_TRIES) begin
							res_d = RES_DENIED;
							lock_start = 1'b1;
							call_d = (guard_act_q[GUARD_LOCK_LSB +: 8] != 8'h00)
								? SBG_LOCKED : SBG_IDLE;
						end
					end
				end
				default: res_d = RES_ERROR;
			endcase
		end
		if (call_q == SBG_LOCKED && !lock_busy && !lock_start) begin
			call_d = SBG_IDLE;
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < 10; i++) begin
				sec_q[i] <= 64'h0;
				ip_q[i] <= 32'h0;
			end
			frame_q <= {8'h0, FRAME_UDL_RST, FRAME_FIX_RST, 5'h0, FRAME_FMT_RST, FRAME_EN_RST};
			frame_act_q <= {8'h0, FRAME_UDL_RST, FRAME_FIX_RST, 5'h0, FRAME_FMT_RST, FRAME_EN_RST};
			guard_q <= {16'h0, LOCK_MIN_RST, 7'h0, GUARD_EN_RST};
			guard_act_q <= {16'h0, LOCK_MIN_RST, 7'h0, GUARD_EN_RST};
			cmd_q <= 4'h0;
			idx_q <= 4'h0;
			arg_q <= 64'h0;
			resp_q <= 64'h0;
			res_q <= 4'h0;
			tries_q <= 8'h00;
			att_q <= 2'h0;
			cfg_q <= 1'b0;
			call_q <= SBG_IDLE;
			go_q <= 1'b0;
			caller_q <= 32'h0;
		end else begin
			sec_q <= sec_d;
			ip_q <= ip_d;
			frame_q <= frame_d;
			frame_act_q <= frame_act_d;
			guard_q <= guard_d;
			guard_act_q <= guard_act_d;
			cmd_q <= cmd_d;
			idx_q <= idx_d;
			arg_q <= arg_d;
			resp_q <= resp_d;
			res_q <= res_d;
			tries_q <= tries_d;
			att_q <= att_d;
			cfg_q <= cfg_d;
			call_q <= call_d;
			go_q <= go_d;
			caller_q <= caller_d;
		end
	end
endmodule

// ---- tb/sbg_sva.sv ----
// port checks for the block former and access guard
`timescale 1ns/10ps
module sbg_sva #(
	parameter int TOTAL_CYC = 200,
	parameter int GAP_CYC = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// serial and status
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic blk_flush,
	input wire logic [1:0] blk_cause,
	input wire logic [7:0] blk_count,
	input wire logic config_mode,
	input wire logic link_up
);
	default clocking cb @(posedge core_clk); endclocking
	// =====
	// age, idle gap and byte count since the last forward
	logic pend_q;
	logic [31:0] age_q;
	logic [31:0] idle_q;
	logic [7:0] cnt_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pend_q <= 1'b0;
			age_q <= '0;
			idle_q <= '0;
			cnt_q <= 8'h00;
		end else if (rx_valid) begin
			pend_q <= 1'b1;
			idle_q <= '0;
			age_q <= (pend_q && !blk_flush) ? age_q + 1 : '0;
			cnt_q <= blk_flush ? 8'h01 : cnt_q + 8'h01;
		end else if (blk_flush) begin
			pend_q <= 1'b0;
			age_q <= '0;
			idle_q <= '0;
			cnt_q <= 8'h00;
		end else if (pend_q) begin
			age_q <= age_q + 1;
			idle_q <= idle_q + 1;
		end
	end
	// =====
	// assertions
	a_total_late: assert property (disable iff (rst) pend_q |-> age_q <= TOTAL_CYC + 2)
		else $error("total-read forward too late");
	a_total_early: assert property (disable iff (rst)
		blk_flush && blk_cause == 2'h0 |-> age_q >= TOTAL_CYC - 1)
		else $error("total-read forward too early");
	a_gap_late: assert property (disable iff (rst) pend_q |-> idle_q <= GAP_CYC + 3)
		else $error("gap forward too late");
	a_gap_early: assert property (disable iff (rst)
		blk_flush && blk_cause == 2'h1 |-> idle_q >= GAP_CYC)
		else $error("gap forward too early");
	a_count_match: assert property (disable iff (rst) blk_flush |-> blk_count == cnt_q)
		else $error("forwarded count wrong");
	a_flush_empty: assert property (disable iff (rst) blk_flush |-> pend_q)
		else $error("forward with no bytes");
	a_flush_pulse: assert property (disable iff (rst) blk_flush |=> !blk_flush)
		else $error("forward pulse too long");
	a_reset_quiet: assert property (rst |=> !blk_flush && !config_mode && !link_up)
		else $error("outputs active after reset");
	a_read_idle: assert property (disable iff (rst) !(psel && penable && !pwrite) |-> prdata == '0)
		else $error("read data outside read");
	a_bad_addr: assert property (disable iff (rst) psel && penable && paddr > 8'h28 |-> pslverr)
		else $error("no error on unmapped address");
	c_total: cover property (blk_flush && blk_cause == 2'h0);
	c_gap: cover property (blk_flush && blk_cause == 2'h1);
	c_frame: cover property (blk_flush && blk_cause == 2'h2);
	c_link: cover property ($rose(link_up));
endmodule

// ---- tb/sbg_host.sv ----
// serial host model feeding received bytes
`timescale 1ns/10ps
module sbg_host (
	// clock
	input wire logic core_clk,
	// bytes toward the block
	output logic [7:0] rx_data,
	output logic rx_valid
);
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
	end
	// one byte, then gap idle cycles (gap at least one)
	task automatic send(input logic [7:0] b, input int gap);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		repeat (gap) @(posedge core_clk);
	endtask
endmodule

// ---- tb/tb.sv ----
// testbench for the block former and access guard
`timescale 1ns/10ps
module tb;
	import sbg_pkg::*;
	localparam int TOT = 200;
	localparam int GAP = 20;
	localparam int MIN = 50;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, blk_flush, rx_valid, config_mode, link_up, err;
	logic [1:0] blk_cause, lcause;
	logic [7:0] blk_count, rx_data, lcount;
	logic [31:0] rd;
	int miscompares = 0;
	int cmp_count = 0;
	int nflush = 0;
	sbg_top #(.TOTAL_CYC(TOT), .GAP_CYC(GAP), .MINUTE_CYC(MIN)) dut (.core_clk(core_clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_data(rx_data), .rx_valid(rx_valid), .blk_flush(blk_flush), .blk_cause(blk_cause),
		.blk_count(blk_count), .config_mode(config_mode), .link_up(link_up));
	sbg_host host (.core_clk(core_clk), .rx_data(rx_data), .rx_valid(rx_valid));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (blk_flush === 1'b1) begin
			nflush++;
			lcause = blk_cause;
			lcount = blk_count;
		end
	end
	// =====
	// shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("compares=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 20) begin
			miscompares++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task cmd(input logic [3:0] c, input logic [3:0] idx, input logic [63:0] arg,
		input logic [3:0] res);
		apb(1'b1, REG_CTRL, {24'h0, idx, 4'h0});
		apb(1'b1, REG_ARG_LO, arg[31:0]);
		apb(1'b1, REG_ARG_HI, arg[63:32]);
		apb(1'b1, REG_CMD, {28'h0, c});
		@(posedge core_clk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({28'h0, rd[3:0]}, {28'h0, res});
	endtask
	task wait_flush(input int base, input int lim);
		int n;
		n = 0;
		while (nflush == base && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		if (n == lim) begin
			miscompares++;
			end_of_test();
		end
	endtask
	task send_frame;
		logic [7:0] f [8];
		f = '{8'h68, 8'h02, 8'h02, 8'h68, 8'h01, 8'h02, 8'h03, 8'h16};
		foreach (f[i]) host.send(f[i], 1);
	endtask
	// =====
	// scenarios
	task t_reset;
		chk({29'h0, blk_flush, config_mode, link_up}, 32'h0);
		apb(1'b0, REG_FRAME, 32'h0);
		chk(rd, 32'h0002_0202);
		apb(1'b0, REG_GUARD, 32'h0);
		chk(rd, 32'h0000_0300);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({20'h0, rd[15:4]}, 32'h1);
		apb(1'b0, 8'h2C, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask
	task t_timers;
		int b;
		b = nflush;
		for (int i = 0; i < 14; i++) host.send(8'h30 + 8'(i), 14);
		wait_flush(b, 40);
		chk({22'h0, lcause, lcount}, {22'h0, 2'h0, 8'h0E});
		b = nflush;
		repeat (3) host.send(8'h41, 4);
		wait_flush(b, GAP + 8);
		chk({22'h0, lcause, lcount}, {22'h0, 2'h1, 8'h03});
		repeat (TOT) @(posedge core_clk);
		chk(32'(nflush), 32'(b + 1));
	endtask
	task t_frame;
		int b;
		cmd(SBG_CMD_ENTER, 4'h0, 64'h0, RES_OK);
		chk({31'h0, config_mode}, 32'h1);
		apb(1'b1, REG_FRAME, 32'h0002_0203);
		cmd(SBG_CMD_SAVE, 4'h0, 64'h0, RES_OK);
		b = nflush;
		send_frame();
		wait_flush(b, 4);
		chk({22'h0, lcause, lcount}, {22'h0, 2'h2, 8'h08});
		cmd(SBG_CMD_LEAVE, 4'h0, 64'h0, RES_OK);
		chk({31'h0, config_mode}, 32'h0);
		cmd(SBG_CMD_FACTORY, 4'h0, 64'h0, RES_OK);
		apb(1'b0, REG_FRAME, 32'h0);
		chk(rd, 32'h0002_0202);
		b = nflush;
		send_frame();
		wait_flush(b, GAP + 8);
		chk({30'h0, lcause}, 32'h1);
	endtask
	task t_guard;
		cmd(SBG_CMD_ENTER, 4'h0, 64'h0, RES_OK);
		cmd(SBG_CMD_SET_MASTER, 4'h0, 64'h6261, RES_OK);
		cmd(SBG_CMD_SET_USER, 4'h1, 64'h7770, RES_OK);
		cmd(SBG_CMD_QUERY_SECRET, 4'h1, 64'h0, RES_OK);
		apb(1'b0, REG_RESP_LO, 32'h0);
		chk(rd, 32'h0000_7770);
		apb(1'b1, REG_GUARD, 32'h0000_0101);
		cmd(SBG_CMD_SAVE, 4'h0, 64'h0, RES_OK);
		cmd(SBG_CMD_LEAVE, 4'h0, 64'h0, RES_OK);
		cmd(SBG_CMD_ENTER, 4'h0, 64'h0, RES_ERROR);
		apb(1'b1, REG_CALL, 32'h0A00_0001);
		cmd(SBG_CMD_CALL, 4'h0, 64'h0, RES_PROMPT);
		cmd(SBG_CMD_SECRET, 4'h0, 64'h6261, RES_WRONG);
		cmd(SBG_CMD_SECRET, 4'h0, 64'h0031, RES_WRONG);
		cmd(SBG_CMD_SECRET, 4'h0, 64'h0032, RES_DENIED);
		cmd(SBG_CMD_CALL, 4'h0, 64'h0, RES_DENIED);
		repeat (MIN + 20) @(posedge core_clk);
		cmd(SBG_CMD_CALL, 4'h0, 64'h0, RES_PROMPT);
		cmd(SBG_CMD_SECRET, 4'h0, 64'h5750, RES_CONNECT);
		chk({31'h0, link_up}, 32'h1);
	endtask
	task t_callers;
		cmd(SBG_CMD_ENTER, 4'h0, 64'h4241, RES_OK);
		cmd(SBG_CMD_SET_CALLER, 4'h3, 64'h0A00_0002, RES_OK);
		cmd(SBG_CMD_LIST_CALLERS, 4'h3, 64'h0, RES_OK);
		apb(1'b0, REG_RESP_LO, 32'h0);
		chk(rd, 32'h0A00_0002);
		apb(1'b0, REG_CTRL, 32'h0);
		chk({28'h0, rd[7:4]}, 32'h4);
		cmd(SBG_CMD_LIST_SECRETS, 4'h1, 64'h0, RES_OK);
		apb(1'b0, REG_RESP_LO, 32'h0);
		chk(rd, 32'h0000_7770);
		cmd(SBG_CMD_CALL, 4'h0, 64'h0, RES_DENIED);
		apb(1'b1, REG_CALL, 32'h0A00_0002);
		cmd(SBG_CMD_CALL, 4'h0, 64'h0, RES_PROMPT);
		cmd(SBG_CMD_SET_CALLER, 4'h3, 64'h0, RES_OK);
		cmd(SBG_CMD_QUERY_CALLER, 4'h3, 64'h0, RES_OK);
		apb(1'b0, REG_RESP_LO, 32'h0);
		chk(rd, 32'h0);
		cmd(SBG_CMD_SET_MASTER, 4'h0, 64'h0, RES_OK);
		cmd(SBG_CMD_LEAVE, 4'h0, 64'h0, RES_OK);
		cmd(SBG_CMD_ENTER, 4'h0, 64'h7A, RES_OK);
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_timers();
		t_frame();
		t_guard();
		t_callers();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		end_of_test();
	end
endmodule
bind sbg_top sbg_sva #(.TOTAL_CYC(TOTAL_CYC), .GAP_CYC(GAP_CYC)) u_sva (.core_clk(core_clk),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_data(rx_data), .rx_valid(rx_valid), .blk_flush(blk_flush), .blk_cause(blk_cause),
	.blk_count(blk_count), .config_mode(config_mode), .link_up(link_up));
